// [rtl/nmiu_core.sv]
/*
 * non-maskable interrupt unit: pin edge detect with filter, watchdog
 * routing, entry save and vectoring, pending hold, return restore,
 * maskable default-priority pick, apb register slave.
 * assumes the cpu core presents next and current pc and return pulses
 * synchronous to sys_clk and loads pc when pcLoad pulses.
 * assumes all inputs, the pin included, are synchronous to sys_clk,
 * that maskReqIn levels stay up until granted, and that software
 * keeps the active flag alone during service and selects no edge
 * while the shared port bit drives out.
 */
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps

module nmiu_core
    import nmiu_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // sources
    input wire logic nmiPin,
    input wire logic watchdogOverflow,
    input wire logic stopMode,
    // maskable requests, bit 0 highest
    input wire logic [`NMIU_NUM_MASK-1:0] maskReqIn,
    // cpu core
    input wire logic [31:0] nextPc,
    input wire logic [31:0] currentPc,
    input wire logic divideActive,
    input wire logic returnFromInterrupt,
    // results
    output logic pcLoad,
    output logic [31:0] pcValue,
    output logic nmiTaken,
    output logic maskGrant,
    output logic [2:0] maskGrantId,
    output logic watchdogMaskReq,
    output logic stopWake,
    output logic [31:0] statusWord
);

    // register map, byte offsets on the apb:
    //   00 rising-edge enable, bit 0 is the dedicated pin
    //   04 falling-edge enable, bit 0 is the dedicated pin
    //   08 watchdog mode, bit 4 routes overflow as non-maskable
    //   0c status word: bit 5 disable, bit 6 exception, bit 7 active
    //   10 fatal saved pc, 14 fatal saved status
    //   18 cause, upper half written on entry
    //   1c status: filtered pin, pin pend, watchdog pend, last source
    //   20 bit set, 24 bit clear: wdata[7:0] rising, [15:8] falling
    // entry walk: idle (save pc, status) -> save (cause, flags)
    //   -> vect (pc load) -> idle; return walk: idle -> ret -> idle.
    // the status word write is refused while either walk runs, so a
    // software load can never tear a hardware update.
    // pin wins over watchdog when both pend; the other pend bit waits.
    nmiu_state_reg_type st_reg;
    nmiu_state_reg_type st_next;

    logic [7:0] wByte;
    logic [7:0] wSet;
    logic [7:0] wClr;
    logic setup;
    logic edgeRise;
    logic edgeFall;
    logic pinEvent;
    logic wdtFatal;
    logic npFlag;
    logic apbRead;
    logic apbWrite;
    logic fatalPend;
    logic maskOpen;

    always_comb begin
        st_next = st_reg;
        wByte = pwdata[7:0];
        wSet = pwdata[7:0];
        wClr = pwdata[15:8];
        setup = psel && !penable;
        npFlag = st_reg.program_status_word[`NMIU_PSW_NP];
        apbRead = setup && !pwrite;
        apbWrite = setup && pwrite;
        fatalPend = st_reg.pinPend || st_reg.wdtPend;
        maskOpen = !npFlag && !st_reg.program_status_word[`NMIU_PSW_ID] && !fatalPend &&
                   st_reg.state == NMIU_IDLE;
        st_next.pcLoad = 1'b0;
        st_next.nmiTaken = 1'b0;
        st_next.maskReq = 1'b0;
        st_next.stopWake = 1'b0;

        // filter: level must hold for the interval before it counts
        st_next.pinSync = nmiPin;
        edgeRise = 1'b0;
        edgeFall = 1'b0;
        if (stopMode) begin
            // clock-based filter bypassed; wake on raw enabled edge
            st_next.filtCnt = '0;
            if (st_reg.pinSync != st_reg.pinStable) begin
                st_next.pinStable = st_reg.pinSync;
                edgeRise = st_reg.pinSync;
                edgeFall = !st_reg.pinSync;
            end
        end else if (st_reg.pinSync == st_reg.pinStable) begin
            st_next.filtCnt = '0;
        end else if (st_reg.filtCnt ==
                     `NMIU_FCNT_W'(`NMIU_FILTER_CYC - 1)) begin
            st_next.filtCnt = '0;
            st_next.pinStable = st_reg.pinSync;
            edgeRise = st_reg.pinSync;
            edgeFall = !st_reg.pinSync;
        end else begin
            st_next.filtCnt = st_reg.filtCnt + `NMIU_FCNT_W'(1);
        end
        pinEvent = (edgeRise && st_reg.riseEn[`NMIU_PIN_BIT]) ||
                   (edgeFall && st_reg.fallEn[`NMIU_PIN_BIT]);
        if (pinEvent && stopMode) begin
            st_next.stopWake = 1'b1;
        end

        wdtFatal = watchdogOverflow && st_reg.wdtMode[`NMIU_WATCHDOG_MODE_REG_KIND];
        st_next.wdtMaskOut = watchdogOverflow &&
                             !st_reg.wdtMode[`NMIU_WATCHDOG_MODE_REG_KIND];

        // one pending bit per source; repeats merge into it
        if (pinEvent) begin
            st_next.pinPend = 1'b1;
        end
        if (wdtFatal) begin
            st_next.wdtPend = 1'b1;
        end

        // maskable pick only when not disabled and not in fatal service
        if (maskOpen) begin
            for (int i = `NMIU_NUM_MASK - 1; i >= 0; i--) begin
                if (maskReqIn[i]) begin
                    st_next.maskReq = 1'b1;
                    st_next.maskId = 3'(i);
                end
            end
        end

        unique case (st_reg.state)
            NMIU_IDLE: begin
                // disable flag not consulted for fatal requests
                if (!npFlag && fatalPend) begin
                    st_next.srcWdt = !st_reg.pinPend;
                    if (st_reg.pinPend) begin
                        st_next.pinPend = pinEvent;
                    end else begin
                        st_next.wdtPend = wdtFatal;
                    end
                    // a divide in flight is restarted, so its own pc is saved
                    if (divideActive) begin
                        st_next.fatalPc = currentPc;
                    end else begin
                        st_next.fatalPc = nextPc;
                    end
                    st_next.fatalPsw = st_reg.program_status_word;
                    st_next.state = NMIU_SAVE;
                end else if (returnFromInterrupt && npFlag &&
                             !st_reg.program_status_word[`NMIU_PSW_EP]) begin
                    st_next.state = NMIU_RET;
                end
            end
            NMIU_SAVE: begin
                // lower half of the cause register is left to software
                if (st_reg.srcWdt) begin
                    st_next.causeReg[31:16] = `NMIU_CAUSE_WDT;
                end else begin
                    st_next.causeReg[31:16] = `NMIU_CAUSE_PIN;
                end
                st_next.program_status_word[`NMIU_PSW_NP] = 1'b1;
                st_next.program_status_word[`NMIU_PSW_ID] = 1'b1;
                st_next.program_status_word[`NMIU_PSW_EP] = 1'b0;
                st_next.state = NMIU_VECT;
            end
            NMIU_VECT: begin
                // handler load comes last, after cause and flags settle
                if (st_reg.srcWdt) begin
                    st_next.pcValue = `NMIU_VEC_WDT;
                end else begin
                    st_next.pcValue = `NMIU_VEC_PIN;
                end
                st_next.pcLoad = 1'b1;
                st_next.nmiTaken = 1'b1;
                st_next.state = NMIU_IDLE;
            end
            NMIU_RET: begin
                // restore both in the same cycle as the jump; pending sources wait
                st_next.program_status_word = st_reg.fatalPsw;
                st_next.pcValue = st_reg.fatalPc;
                st_next.pcLoad = 1'b1;
                st_next.state = NMIU_IDLE;
            end
        endcase

        // apb: one wait-free access, answer in the access cycle
        st_next.pready = setup;
        st_next.pslverr = 1'b0;
        if (apbRead) begin
            unique case (paddr)
                `NMIU_OFS_RISE: begin
                    st_next.prdata = {24'h0, st_reg.riseEn};
                end
                `NMIU_OFS_FALL: begin
                    st_next.prdata = {24'h0, st_reg.fallEn};
                end
                `NMIU_OFS_WATCHDOG_MODE_REG: begin
                    st_next.prdata = {24'h0, st_reg.wdtMode};
                end
                `NMIU_OFS_PSW: begin
                    st_next.prdata = st_reg.program_status_word;
                end
                `NMIU_OFS_FATAL_SAVED_PC: begin
                    st_next.prdata = st_reg.fatalPc;
                end
                `NMIU_OFS_FATAL_SAVED_STATUS: begin
                    st_next.prdata = st_reg.fatalPsw;
                end
                `NMIU_OFS_ECR: begin
                    st_next.prdata = st_reg.causeReg;
                end
                `NMIU_OFS_STAT: begin
                    st_next.prdata = {28'h0, st_reg.srcWdt, st_reg.wdtPend,
                                      st_reg.pinPend, st_reg.pinStable};
                end
                `NMIU_OFS_BSET, `NMIU_OFS_BCLR: begin
                    st_next.prdata = {16'h0, st_reg.fallEn, st_reg.riseEn};
                end
                default: begin
                    st_next.prdata = 32'h0;
                    st_next.pslverr = 1'b1;
                end
            endcase
        end else if (apbWrite) begin
            st_next.prdata = 32'h0;
            unique case (paddr)
                `NMIU_OFS_RISE: begin
                    st_next.riseEn = wByte;
                end
                `NMIU_OFS_FALL: begin
                    st_next.fallEn = wByte;
                end
                `NMIU_OFS_WATCHDOG_MODE_REG: begin
                    st_next.wdtMode = wByte;
                end
                `NMIU_OFS_PSW: begin
                    // software load of status word; hardware update wins
                    if (st_reg.state == NMIU_IDLE &&
                        st_next.state == NMIU_IDLE) begin
                        st_next.program_status_word = pwdata;
                    end
                end
                `NMIU_OFS_FATAL_SAVED_PC: begin
                    st_next.fatalPc = pwdata;
                end
                `NMIU_OFS_FATAL_SAVED_STATUS: begin
                    st_next.fatalPsw = pwdata;
                end
                `NMIU_OFS_ECR: begin
                    // the entry walk owns the upper half in this cycle
                    if (st_reg.state != NMIU_SAVE) begin
                        st_next.causeReg = pwdata;
                    end
                end
                `NMIU_OFS_BSET: begin
                    st_next.riseEn = st_reg.riseEn | wSet;
                    st_next.fallEn = st_reg.fallEn | wClr;
                end
                `NMIU_OFS_BCLR: begin
                    st_next.riseEn = st_reg.riseEn & ~wSet;
                    st_next.fallEn = st_reg.fallEn & ~wClr;
                end
                `NMIU_OFS_STAT: begin
                    // status is read-only; the write is dropped quietly
                    st_next.pslverr = 1'b0;
                end
                default: begin
                    st_next.pslverr = 1'b1;
                end
            endcase
        end

        if (!rst_b) begin
            // every field named so a new one gets a deliberate value
            st_next.state = NMIU_IDLE;
            st_next.riseEn = `NMIU_BYTE_RESET;
            st_next.fallEn = `NMIU_BYTE_RESET;
            st_next.wdtMode = `NMIU_BYTE_RESET;
            st_next.program_status_word = `NMIU_PSW_RESET;
            st_next.fatalPc = '0;
            st_next.fatalPsw = '0;
            st_next.causeReg = '0;
            st_next.pinSync = '0;
            st_next.pinStable = '0;
            st_next.filtCnt = '0;
            st_next.pinPend = '0;
            st_next.wdtPend = '0;
            st_next.srcWdt = '0;
            st_next.pcLoad = '0;
            st_next.pcValue = '0;
            st_next.nmiTaken = '0;
            st_next.maskReq = '0;
            st_next.maskId = '0;
            st_next.wdtMaskOut = '0;
            st_next.stopWake = '0;
            st_next.prdata = '0;
            st_next.pready = '0;
            st_next.pslverr = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        st_reg <= st_next;
    end

    // every output straight from its flip-flop
    assign prdata = st_reg.prdata;
    assign pready = st_reg.pready;
    assign pslverr = st_reg.pslverr;
    assign pcLoad = st_reg.pcLoad;
    assign pcValue = st_reg.pcValue;
    assign nmiTaken = st_reg.nmiTaken;
    assign maskGrant = st_reg.maskReq;
    assign maskGrantId = st_reg.maskId;
    assign watchdogMaskReq = st_reg.wdtMaskOut;
    assign stopWake = st_reg.stopWake;
    assign statusWord = st_reg.program_status_word;

endmodule

// [rtl/nmiu_params.svh]
/*
 * constants of the non-maskable interrupt unit: register offsets,
 * status word bit positions, cause codes, handler addresses, timing.
 * assumes inclusion by bare name from the package and the design.
 */
`ifndef NMIU_PARAMS_SVH
`define NMIU_PARAMS_SVH

// apb byte offsets
`define NMIU_OFS_RISE 12'h000
`define NMIU_OFS_FALL 12'h004
`define NMIU_OFS_WATCHDOG_MODE_REG 12'h008
`define NMIU_OFS_PSW 12'h00c
`define NMIU_OFS_FATAL_SAVED_PC 12'h010
`define NMIU_OFS_FATAL_SAVED_STATUS 12'h014
`define NMIU_OFS_ECR 12'h018
`define NMIU_OFS_STAT 12'h01c
`define NMIU_OFS_BSET 12'h020
`define NMIU_OFS_BCLR 12'h024

// status word bit positions
`define NMIU_PSW_ID 5
`define NMIU_PSW_EP 6
`define NMIU_PSW_NP 7

// watchdog mode kind select bit
`define NMIU_WATCHDOG_MODE_REG_KIND 4

// dedicated pin bit in the edge enable registers
`define NMIU_PIN_BIT 0

`define NMIU_CAUSE_PIN 16'h0010
`define NMIU_CAUSE_WDT 16'h0020
`define NMIU_VEC_PIN 32'h0000_0010
`define NMIU_VEC_WDT 32'h0000_0020

`define NMIU_PSW_RESET 32'h0000_0020
`define NMIU_BYTE_RESET 8'h00

// pin filter interval in ns, and derived cycle count at 5 ns
`define NMIU_FILTER_NS 100
`define NMIU_CLK_NS 5
`define NMIU_FILTER_CYC ((`NMIU_FILTER_NS + `NMIU_CLK_NS - 1) / `NMIU_CLK_NS)
`define NMIU_FCNT_W 6

// maskable request count
`define NMIU_NUM_MASK 8

`endif

// [rtl/nmiu_pkg.sv]
/*
 * types of the non-maskable interrupt unit.
 * assumes nmiu_params.svh on the include path.
 */
`include "nmiu_params.svh"

package nmiu_pkg;

    typedef enum logic [1:0] {
        NMIU_IDLE = 2'b00,
        NMIU_SAVE = 2'b01,
        NMIU_VECT = 2'b10,
        NMIU_RET = 2'b11
    } nmiu_state_type;

    typedef struct packed {
        nmiu_state_type state;
        logic [7:0] riseEn;
        logic [7:0] fallEn;
        logic [7:0] wdtMode;
        logic [31:0] program_status_word;
        logic [31:0] fatalPc;
        logic [31:0] fatalPsw;
        logic [31:0] causeReg;
        logic pinSync;
        logic pinStable;
        logic [`NMIU_FCNT_W-1:0] filtCnt;
        logic pinPend;
        logic wdtPend;
        logic srcWdt;
        logic pcLoad;
        logic [31:0] pcValue;
        logic nmiTaken;
        logic maskReq;
        logic [2:0] maskId;
        logic wdtMaskOut;
        logic stopWake;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } nmiu_state_reg_type;

endpackage

// [sim/nmiu_core_tb.sv]
/* self-checking bench of the nmi unit.
   assumes the monitor binds itself and the source model drives pins. */
`timescale 1ns/1ps
module nmiu_core_tb;
    logic sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
    logic nmiPin, watchdogOverflow, stopMode, divideActive, quiet, seen;
    logic returnFromInterrupt, pcLoad, nmiTaken, maskGrant, stopWake;
    logic watchdogMaskReq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, nextPc, currentPc, pcValue, statusWord, rdv;
    logic [7:0] maskReqIn;
    logic [2:0] maskGrantId;
    logic [32:0] expQ[$];
    int nMismatch = 0, checkCount = 0, nTaken = 0, t;
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    nmiu_core nmiu_core_i(.sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .nmiPin, .watchdogOverflow,
        .stopMode, .maskReqIn, .nextPc, .currentPc, .divideActive,
        .returnFromInterrupt, .pcLoad, .pcValue, .nmiTaken, .maskGrant,
        .maskGrantId, .watchdogMaskReq, .stopWake, .statusWord);
    nmiu_source_model nmiu_source_model_i(.sys_clk, .nmiPin,
        .watchdogOverflow);
    task complete_run();
        $display("counts: %0d compared, %0d wrong", checkCount, nMismatch);
        if (nMismatch == 0 && checkCount > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task check_value(input logic [32:0] got, input logic [32:0] x);
        checkCount++;
        if (got !== x) begin
            nMismatch++;
            $display("wrong value at %0t: %h expected %h", $time, got, x);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        int n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            nMismatch++;
            complete_run();
        end
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rdv, err);
    endtask
    task rd_chk(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0, rdv, err);
        check_value(rdv, x);
    endtask
    task automatic wait_taken(input int minCyc);
        int n = 0;
        while (nmiTaken !== 1'b1) begin
            @(posedge sys_clk);
            n++;
            if (n > 200) begin
                nMismatch++;
                complete_run();
            end
        end
        check_value(n >= minCyc, 1'b1);
    endtask
    task ret_pulse();
        returnFromInterrupt <= 1'b1;
        tick(1);
        returnFromInterrupt <= 1'b0;
        tick(4);
    endtask
    // one entry and return, then a second entry and return for extra watchdog pulses sent while in service
    task automatic serve(input int src, input int extra);
        int t0 = nTaken;
        logic [31:0] low, pc, vec;
        low = $urandom;
        vec = (src == 2) ? 32'h20 : 32'h10;
        wr(12'h018, low);
        pc = divideActive ? currentPc : nextPc;
        repeat ((extra > 0) ? 2 : 1) begin
            expQ.push_back({1'b1, vec});
            expQ.push_back({1'b0, pc});
        end
        if (src == 2) nmiu_source_model_i.wdt_pulse();
        else nmiu_source_model_i.pin_set(src == 0);
        wait_taken((src == 2) ? 0 : 20);
        rd_chk(12'h010, pc);
        rd_chk(12'h014, 32'h20);
        rd_chk(12'h018, {vec[15:0], low[15:0]});
        repeat (extra) nmiu_source_model_i.wdt_pulse();
        ret_pulse();
        if (extra > 0) begin
            wait_taken(0);
            ret_pulse();
        end
        tick(30);
        check_value(nTaken, t0 + 1 + (extra > 0));
        check_value(statusWord, 32'h20);
    endtask
    task pin_edge(input logic lvl, input logic en);
        if (en) serve(lvl ? 0 : 1, 0);
        else begin
            t = nTaken;
            nmiu_source_model_i.pin_set(lvl);
            tick(40);
            check_value(nTaken, t);
        end
    endtask
    always @(posedge sys_clk) begin
        if (rst_b === 1'b1 && pcLoad === 1'b1 && !quiet) begin
            if (expQ.size() == 0) check_value(pcLoad, 1'b0);
            else check_value({nmiTaken, pcValue}, expQ.pop_front());
        end
        if (nmiTaken === 1'b1) nTaken <= nTaken + 1;
    end
    initial begin
        {rst_b, psel, penable, pwrite, stopMode, divideActive, quiet} = 7'h0;
        {paddr, pwdata, maskReqIn, returnFromInterrupt} = 53'h0;
        void'($urandom(32'hfed0155b));
        nextPc = $urandom;
        currentPc = $urandom;
        tick(10);
        rst_b <= 1'b1;
        rd_chk(12'h000, 32'h0);
        rd_chk(12'h004, 32'h0);
        apb(1'b0, 12'h0f0, 32'h0, rdv, err);
        check_value(err, 1'b1);
        $display("reset test done");
        for (int k = 0; k < 4; k++) begin
            wr(12'h024, 32'hffff);
            wr(12'h020, {23'h0, k[1], 7'h0, k[0]});
            rd_chk(12'h004, {31'h0, k[1]});
            pin_edge(1'b1, k[0]);
            pin_edge(1'b0, k[1]);
        end
        t = nTaken;
        nmiu_source_model_i.pin_set(1'b1);
        tick(8);
        nmiu_source_model_i.pin_set(1'b0);
        tick(40);
        check_value(nTaken, t);
        $display("pin edge test done");
        wr(12'h008, 32'h10);
        serve(2, 0);
        divideActive <= 1'b1;
        serve(2, 3);
        wr(12'h008, 32'h0);
        t = nTaken;
        seen = 1'b0;
        fork
            nmiu_source_model_i.wdt_pulse();
            repeat (4) begin
                @(posedge sys_clk);
                seen = seen | watchdogMaskReq;
            end
        join
        check_value({seen, nTaken}, {1'b1, t});
        $display("watchdog test done");
        wr(12'h00c, 32'h0);
        repeat (60) begin
            @(posedge sys_clk);
            maskReqIn <= $urandom;
        end
        $display("maskable test done");
        quiet <= 1'b1;
        stopMode <= 1'b1;
        wr(12'h000, 32'h1);
        nmiu_source_model_i.pin_set(1'b1);
        seen = 1'b0;
        repeat (25) begin
            @(posedge sys_clk);
            seen = seen | stopWake;
        end
        check_value(seen, 1'b1);
        $display("stop test done");
        complete_run();
    end
endmodule

// [sim/nmiu_monitor.sv]
/* port checker of the nmi unit.
   assumes it is bound into nmiu_core, one clock domain. */
`timescale 1ns/1ps
module nmiu_monitor(
    // clock, reset, apb
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    // core side
    input wire logic [7:0] maskReqIn,
    input wire logic returnFromInterrupt,
    input wire logic stopMode,
    // results
    input wire logic pcLoad,
    input wire logic [31:0] pcValue,
    input wire logic nmiTaken,
    input wire logic maskGrant,
    input wire logic [2:0] maskGrantId,
    input wire logic stopWake,
    input wire logic [31:0] statusWord
);
    logic [7:0] reqPrev;
    always_ff @(posedge sys_clk) begin
        reqPrev <= maskReqIn;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    a_taken_vector: assert property (nmiTaken |-> pcLoad &&
        (pcValue == 32'h10 || pcValue == 32'h20)) else $error("bad vector");
    a_entry_flags: assert property (nmiTaken |->
        statusWord[7:5] == 3'b101) else $error("bad entry flags");
    a_mask_blocked: assert property (maskGrant |->
        !$past(statusWord[7]) && !$past(statusWord[5]))
        else $error("grant while masked");
    a_grant_prio: assert property (maskGrant |->
        reqPrev[maskGrantId] &&
        (reqPrev & ((8'h01 << maskGrantId) - 8'h01)) == 8'h00)
        else $error("grant not highest");
    a_single_entry: assert property (nmiTaken |=> !nmiTaken)
        else $error("entry repeated");
    a_ret_restore: assert property (returnFromInterrupt &&
        statusWord[7] && !statusWord[6] |-> ##[1:3] (pcLoad && !nmiTaken))
        else $error("return without restore");
    a_apb_ready: assert property (psel && !penable |=> pready && penable)
        else $error("apb answer late");
    a_stop_wake: assert property (stopWake |-> $past(stopMode))
        else $error("wake outside stop");
    a_load_cause: assert property (pcLoad |->
        nmiTaken || $past(returnFromInterrupt, 2) ||
        $past(returnFromInterrupt)) else $error("stray pc load");
    cover property (nmiTaken && pcValue == 32'h20);
    cover property (maskGrant);
    cover property (stopWake);
endmodule
bind nmiu_core nmiu_monitor nmiu_monitor_i(.sys_clk, .rst_b, .psel, .penable,
    .pready, .maskReqIn, .returnFromInterrupt, .stopMode, .pcLoad, .pcValue,
    .nmiTaken, .maskGrant, .maskGrantId, .stopWake, .statusWord);

// [sim/nmiu_source_model.sv]
/* pin and watchdog source model of the nmi unit.
   assumes the bench calls its tasks just after a clock edge. */
`timescale 1ns/1ps
module nmiu_source_model(
    // clock
    input wire logic sys_clk,
    // sources
    output logic nmiPin,
    output logic watchdogOverflow
);
    initial begin
        nmiPin = 1'b0;
        watchdogOverflow = 1'b0;
    end
    // a level shorter than the filter interval is a glitch
    task pin_set(input logic lvl);
        nmiPin <= lvl;
    endtask
    // idle edge after the pulse keeps back-to-back pulses apart
    task wdt_pulse();
        watchdogOverflow <= 1'b1;
        @(posedge sys_clk);
        watchdogOverflow <= 1'b0;
        @(posedge sys_clk);
    endtask
endmodule
